// File: logic/aen_event_notifier.sv
// event notification engine driving the ata taskfile
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

module aen_event_notifier
  import aen_pkg::*;
#(
  parameter int STB_CYC = STROBE_CYC,
  parameter int REC_CYC = RECOVERY_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [31:0] reg_rdata_o,
  output logic irq_o,
  // usb events, one-cycle pulses from the usb core, and the eject button level from outside
  input wire logic usb_reset_i,
  input wire logic class_reset_i,
  input wire logic usb_suspend_i,
  input wire logic usb_resume_i,
  input wire logic eject_btn_i,
  // power and speed levels from the usb core
  input wire logic self_powered_i,
  input wire logic bus_powered_i,
  input wire logic high_speed_i,
  input wire logic full_speed_i,
  // ata pio taskfile pins
  output logic [2:0] ata_da_o,
  output logic ata_cs0_n_o,
  output logic ata_dior_n_o,
  output logic ata_diow_n_o,
  input wire logic [7:0] ata_data_i,
  output logic [7:0] ata_data_o,
  output logic ata_data_oe_n_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] step_addr(input logic [2:0] step);
    logic [2:0] a;
    a = TF_CMD;
    unique case (step)
      STEP_FEAT: a = TF_FEAT;
      STEP_SCNT: a = TF_SCNT;
      STEP_MID, STEP_RMID: a = TF_LBA_MID;
      STEP_HIGH, STEP_RHIGH: a = TF_LBA_HIGH;
      STEP_CMD, STEP_POLL: a = TF_CMD;
    endcase
    return a;
  endfunction : step_addr

  function automatic logic step_is_read(input logic [2:0] step);
    return step >= STEP_POLL;
  endfunction : step_is_read

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // the eject button and the drive's data bus arrive from outside
  logic ej_s1_q, ej_s2_q, ej_prev_q;
  logic [7:0] dat_s1_q, dat_s2_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ej_s1_q <= 1'b0;
      ej_s2_q <= 1'b0;
      ej_prev_q <= 1'b0;
      dat_s1_q <= 8'h00;
      dat_s2_q <= 8'h00;
    end else begin
      ej_s1_q <= eject_btn_i;
      ej_s2_q <= ej_s1_q;
      ej_prev_q <= ej_s2_q;
      dat_s1_q <= ata_data_i;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ------------------------------------------------------------
  // registers and event collection
  // ------------------------------------------------------------
  aen_state_e state_q;
  logic [2:0] step_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] opcode_q;
  logic [7:0] out_lo_q, out_hi_q, ret_lo_q, ret_hi_q, rd_byte_q, feat_q;
  logic [7:0] pend_q;
  logic abort_q;
  logic [1:0] irq_sts_q, irq_msk_q;
  logic [31:0] rdata_q;
  logic [2:0] da_q;
  logic cs0_n_q, dior_n_q, diow_n_q, oe_n_q, irq_q;
  logic [7:0] dout_q;

  wire enabled = (opcode_q != OPCODE_OFF);
  wire [7:0] new_evt = {usb_reset_i, class_reset_i, usb_suspend_i, usb_resume_i,
                        2'b00, ej_s2_q & ~ej_prev_q, ~ej_s2_q & ej_prev_q};
  wire [7:0] scnt_byte = {4'h0, self_powered_i, bus_powered_i, high_speed_i, full_speed_i};
  wire launch = (state_q == AEN_IDLE) && enabled && (pend_q != 8'h00);

  // ------------------------------------------------------------
  // sequence decisions at the end of each access
  // ------------------------------------------------------------
  wire acc_end = (state_q == AEN_RECOV) && (cnt_q == '0);
  wire dev_busy = rd_byte_q[ST_BUSY] | rd_byte_q[ST_DRQ];
  wire seq_abort = acc_end && step_is_read(step_q) && (abort_q || usb_reset_i);
  wire seq_done = acc_end && (step_q == STEP_RHIGH) && !seq_abort;
  wire [2:0] next_step = (step_q == STEP_POLL && dev_busy) ? STEP_POLL : step_q + 3'h1;
  wire seq_next = acc_end && !seq_abort && !seq_done;
  wire start_acc = launch || seq_next;
  wire [2:0] acc_step = launch ? STEP_FEAT : next_step;

  logic [7:0] wr_byte;
  always_comb begin
    wr_byte = 8'h00;
    unique case (acc_step)
      STEP_FEAT: wr_byte = launch ? pend_q : feat_q;
      STEP_SCNT: wr_byte = scnt_byte;
      STEP_MID: wr_byte = out_lo_q;
      STEP_HIGH: wr_byte = out_hi_q;
      STEP_CMD: wr_byte = opcode_q;
      STEP_POLL, STEP_RMID, STEP_RHIGH: wr_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  wire wr_opcode = reg_we_i && (reg_addr_i == OPCODE_OFS);
  wire wr_irq_sts = reg_we_i && (reg_addr_i == IRQ_STS_OFS);
  wire wr_irq_msk = reg_we_i && (reg_addr_i == IRQ_MSK_OFS);
  wire [1:0] irq_set = {seq_abort, seq_done};
  wire [1:0] irq_sts_d = irq_set | (irq_sts_q & ~(wr_irq_sts ? reg_wdata_i[1:0] : 2'b00));
  wire busy = (state_q != AEN_IDLE);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (reg_addr_i)
      STATE_OFS: rd_mux = {ret_hi_q, ret_lo_q, out_hi_q, out_lo_q};
      STAT_OFS: rd_mux = {16'h0000, pend_q, 5'h00, step_q};
      OPCODE_OFS: rd_mux = {24'h000000, opcode_q};
      IRQ_STS_OFS: rd_mux = {30'h0, irq_sts_q};
      IRQ_MSK_OFS: rd_mux = {30'h0, irq_msk_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      opcode_q <= OPCODE_RST;
      irq_msk_q <= IRQ_RST;
    end else begin
      if (wr_opcode) begin
        opcode_q <= reg_wdata_i[7:0];
      end
      if (wr_irq_msk) begin
        irq_msk_q <= reg_wdata_i[1:0];
      end
    end
  end

  // a status set beats a clear written in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_sts_q <= IRQ_RST;
      irq_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_q <= |(irq_sts_d & irq_msk_q);
      rdata_q <= reg_re_i ? rd_mux : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------
  // pending events and saved state bytes
  // ------------------------------------------------------------
  // events arriving while a notification runs wait for the next one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_q <= 8'h00;
      feat_q <= 8'h00;
    end else if (!enabled) begin
      pend_q <= 8'h00;
    end else if (launch) begin
      feat_q <= pend_q;
      pend_q <= new_evt;
    end else begin
      pend_q <= pend_q | new_evt;
    end
  end

  // a usb reset during a read step spoils the read-back
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      abort_q <= 1'b0;
    end else if (launch || seq_abort || seq_done) begin
      abort_q <= 1'b0;
    end else if (usb_reset_i && busy && step_is_read(step_q)) begin
      abort_q <= 1'b1;
    end
  end

  // saved bytes survive suspend; only the chip reset clears them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_lo_q <= STATE_RST;
      out_hi_q <= STATE_RST;
      ret_lo_q <= STATE_RST;
      ret_hi_q <= STATE_RST;
    end else begin
      if (acc_end && step_q == STEP_RMID && !seq_abort) begin
        ret_lo_q <= rd_byte_q;
      end
      if (seq_done) begin
        ret_hi_q <= rd_byte_q;
        out_lo_q <= ret_lo_q;
        out_hi_q <= rd_byte_q;
      end
    end
  end

  // ------------------------------------------------------------
  // pio access engine
  // ------------------------------------------------------------
  // one access: setup, strobe, recovery; read data is taken at the
  // last strobe cycle, two cycles late through the synchroniser
  wire cur_read = step_is_read(step_q);
  wire cnt_zero = (cnt_q == '0);
  wire stb_start = (state_q == AEN_SETUP);
  wire stb_end = (state_q == AEN_STROBE) && cnt_zero;
  aen_state_e state_d;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      AEN_IDLE: begin
        if (launch) begin
          state_d = AEN_SETUP;
        end
      end
      AEN_SETUP: begin
        state_d = AEN_STROBE;
        cnt_d = CNT_W'(STB_CYC - 1);
      end
      AEN_STROBE: begin
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_zero) begin
          state_d = AEN_RECOV;
          cnt_d = CNT_W'(REC_CYC - 1);
        end
      end
      AEN_RECOV: begin
        cnt_d = cnt_q - CNT_W'(1);
        if (acc_end) begin
          state_d = seq_next ? AEN_SETUP : AEN_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= AEN_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // strobes open after the setup cycle and close before recovery
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dior_n_q <= 1'b1;
      diow_n_q <= 1'b1;
    end else if (stb_start) begin
      dior_n_q <= ~cur_read;
      diow_n_q <= cur_read;
    end else if (stb_end) begin
      dior_n_q <= 1'b1;
      diow_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_byte_q <= 8'h00;
    end else if (stb_end && cur_read) begin
      rd_byte_q <= dat_s2_q;
    end
  end

  // select, address and data stay put for the whole access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      step_q <= STEP_FEAT;
      da_q <= 3'h0;
      cs0_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      dout_q <= 8'h00;
    end else if (start_acc) begin
      step_q <= acc_step;
      da_q <= step_addr(acc_step);
      cs0_n_q <= 1'b0;
      oe_n_q <= step_is_read(acc_step);
      dout_q <= wr_byte;
    end else if (acc_end) begin
      cs0_n_q <= 1'b1;
      oe_n_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign ata_da_o = da_q;
  assign ata_cs0_n_o = cs0_n_q;
  assign ata_dior_n_o = dior_n_q;
  assign ata_diow_n_o = diow_n_q;
  assign ata_data_o = dout_q;
  assign ata_data_oe_n_o = oe_n_q;

endmodule : aen_event_notifier

// File: pkg/aen_pkg.sv
// constants shared by the event notifier block
package aen_pkg;

  // ------------------------------------------------------------
  // clock and ata pio timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int STROBE_NS = 165;
  localparam int RECOVERY_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVERY_CYC = (RECOVERY_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  // ------------------------------------------------------------
  // register port map, index times four is the byte address
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] OPCODE_IDX = 8'h02;
  localparam logic [ADDR_W-1:0] OPCODE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_MSK_OFS = 8'h10;
  localparam logic [7:0] OPCODE_RST = 8'h00;
  localparam logic [7:0] OPCODE_OFF = 8'h00;
  localparam logic [7:0] STATE_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;

  // ------------------------------------------------------------
  // taskfile addresses and field layout
  // ------------------------------------------------------------
  localparam logic [2:0] TF_FEAT = 3'h1;
  localparam logic [2:0] TF_SCNT = 3'h2;
  localparam logic [2:0] TF_LBA_MID = 3'h4;
  localparam logic [2:0] TF_LBA_HIGH = 3'h5;
  localparam logic [2:0] TF_CMD = 3'h7;
  localparam int ST_BUSY = 7;
  localparam int ST_DRQ = 3;
  localparam int FT_USB_RST = 7;
  localparam int FT_CLASS_RST = 6;
  localparam int FT_SUSPEND = 5;
  localparam int FT_RESUME = 4;
  localparam int FT_EJ_PRESS = 1;
  localparam int FT_EJ_REL = 0;

  // ------------------------------------------------------------
  // notification sequence steps and access states
  // ------------------------------------------------------------
  localparam logic [2:0] STEP_FEAT = 3'h0;
  localparam logic [2:0] STEP_SCNT = 3'h1;
  localparam logic [2:0] STEP_MID = 3'h2;
  localparam logic [2:0] STEP_HIGH = 3'h3;
  localparam logic [2:0] STEP_CMD = 3'h4;
  localparam logic [2:0] STEP_POLL = 3'h5;
  localparam logic [2:0] STEP_RMID = 3'h6;
  localparam logic [2:0] STEP_RHIGH = 3'h7;

  typedef enum logic [1:0] {
    AEN_IDLE = 2'b00,
    AEN_SETUP = 2'b01,
    AEN_STROBE = 2'b10,
    AEN_RECOV = 2'b11
  } aen_state_e;

endpackage : aen_pkg

// File: tb/aen_ata_dev.sv
// attached drive model answering notification commands
`timescale 1ns/1ps
module aen_ata_dev (
  // host side pins
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] da_i,
  input wire logic dior_n_i,
  input wire logic diow_n_i,
  input wire logic [7:0] wdata_i,
  // to host and bench
  output logic [7:0] rdata_o,
  output logic [7:0][7:0] tf_o,
  output logic [7:0] cnt_o,
  output logic [14:0] wseq_o,
  output logic [14:0] rseq_o
);
  logic dior_q, diow_q;
  logic [1:0] poll_q;
  logic [7:0] last_q, val;
  // status walks busy, then drq, then idle with unused bits set
  assign val = da_i == 3'h7 ? (poll_q == 2'h0 ? 8'h80 : poll_q == 2'h1 ? 8'h08 : 8'h77) :
    da_i == 3'h4 ? 8'hA0 + cnt_o : da_i == 3'h5 ? 8'hC0 + cnt_o : 8'h00;
  // released bus shows the inverse so a stale sample is caught
  assign rdata_o = dior_n_i ? ~last_q : val;
  always_ff @(posedge clk_i) begin
    dior_q <= dior_n_i;
    diow_q <= diow_n_i;
    if (!dior_n_i) last_q <= val;
    if (rst_i) begin
      cnt_o <= 8'h00;
      poll_q <= 2'h0;
      last_q <= 8'h00;
      tf_o <= 64'h0;
    end else if (diow_n_i && !diow_q) begin
      tf_o[da_i] <= wdata_i;
      wseq_o <= {wseq_o[11:0], da_i};
      // a new command restarts the walk, so a cut-short one leaves no trace
      if (da_i == 3'h7) cnt_o <= cnt_o + 8'h01;
      if (da_i == 3'h7) poll_q <= 2'h0;
    end else if (dior_n_i && !dior_q) begin
      rseq_o <= {rseq_o[11:0], da_i};
      if (da_i == 3'h7 && poll_q != 2'h2) poll_q <= poll_q + 2'h1;
    end
  end
endmodule : aen_ata_dev

// File: tb/aen_notifier_properties.sv
// concurrent checks on the notifier ports
`timescale 1ns/1ps
module aen_notifier_chk
  import aen_pkg::*;
#(
  parameter int STB_CYC = STROBE_CYC
) (
  // clock, reset, register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  // ata pins
  input wire logic [2:0] ata_da_o,
  input wire logic ata_cs0_n_o,
  input wire logic ata_dior_n_o,
  input wire logic ata_diow_n_o,
  input wire logic [7:0] ata_data_o,
  input wire logic ata_data_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic stb;
  logic [7:0] cnt_q, opc_q;
  assign stb = !ata_dior_n_o || !ata_diow_n_o;
  // width counter instead of a repetition, the default width is 42
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      opc_q <= 8'h00;
    end else begin
      cnt_q <= stb ? cnt_q + 8'h01 : 8'h00;
      if (reg_we_i && reg_addr_i == OPCODE_OFS) opc_q <= reg_wdata_i[7:0];
    end
  end
  a_read_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0) else $error("read data outside slot");
  a_strobe_excl: assert property (!(!ata_dior_n_o && !ata_diow_n_o)) else $error("both strobes low");
  a_idle_bus: assert property (ata_cs0_n_o |-> ata_data_oe_n_o && ata_dior_n_o && ata_diow_n_o)
    else $error("bus active while deselected");
  a_oe_write: assert property (!ata_diow_n_o |-> !ata_data_oe_n_o && !ata_cs0_n_o) else $error("write undriven");
  a_oe_read: assert property (!ata_dior_n_o |-> ata_data_oe_n_o && !ata_cs0_n_o) else $error("read driven");
  a_strobe_len: assert property ($fell(stb) |-> cnt_q == STB_CYC) else $error("strobe width wrong");
  a_setup_cycle: assert property ($rose(stb) |-> !$past(ata_cs0_n_o) && $stable(ata_da_o))
    else $error("no setup cycle");
  a_access_hold: assert property (stb && $past(stb) |-> $stable(ata_da_o) && $stable(ata_data_o))
    else $error("access changed mid strobe");
  a_cmd_opcode: assert property (!ata_diow_n_o && ata_da_o == TF_CMD |->
    ata_data_o == opc_q && opc_q != OPCODE_OFF) else $error("command byte wrong");
  a_off_quiet: assert property (opc_q == OPCODE_OFF && ata_cs0_n_o |=> ata_cs0_n_o)
    else $error("access while disabled");
endmodule : aen_notifier_chk

bind aen_event_notifier aen_notifier_chk #(.STB_CYC(STB_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .ata_da_o(ata_da_o), .ata_cs0_n_o(ata_cs0_n_o), .ata_dior_n_o(ata_dior_n_o),
  .ata_diow_n_o(ata_diow_n_o), .ata_data_o(ata_data_o), .ata_data_oe_n_o(ata_data_oe_n_o));

// File: tb/tb_ata_event_notifier.sv
// self-checking bench for the event notifier
`timescale 1ns/1ps
module tb_ata_event_notifier;
  import aen_pkg::*;
  // ----
  // signals
  // ----
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00, n = 8'h00, din, dout, cnt;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic reg_we_i = 1'b0, reg_re_i = 1'b0, eject = 1'b0, irq_o, cs_n, rd_n, wr_n, oe_n;
  logic [3:0] ev = 4'h0, pwr = 4'h0;
  logic [2:0] da;
  logic [7:0][7:0] tf;
  logic [14:0] wseq, rseq;
  logic [15:0] exp_out = 16'h0;
  int fails = 0, checks = 0;
  always #2 clk_i = ~clk_i;
  // short strobes keep each access at five cycles
  aen_event_notifier #(.STB_CYC(3), .REC_CYC(1)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .usb_reset_i(ev[3]), .class_reset_i(ev[2]), .usb_suspend_i(ev[1]), .usb_resume_i(ev[0]), .eject_btn_i(eject),
    .self_powered_i(pwr[3]), .bus_powered_i(pwr[2]), .high_speed_i(pwr[1]), .full_speed_i(pwr[0]),
    .ata_da_o(da), .ata_cs0_n_o(cs_n), .ata_dior_n_o(rd_n), .ata_diow_n_o(wr_n), .ata_data_i(din),
    .ata_data_o(dout), .ata_data_oe_n_o(oe_n));
  aen_ata_dev u_dev (.clk_i(clk_i), .rst_i(rst_i), .da_i(da), .dior_n_i(rd_n), .diow_n_i(wr_n), .wdata_i(dout),
    .rdata_o(din), .tf_o(tf), .cnt_o(cnt), .wseq_o(wseq), .rseq_o(rseq));
  // ----
  // tasks
  // ----
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask : rd
  task automatic pulse(input logic [3:0] e);
    @(posedge clk_i);
    ev <= e;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask : pulse
  task automatic wait_irq();
    int k;
    k = 0;
    while (irq_o !== 1'b1 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 500) chk(32'(k), 32'h0);
    if (k == 500) print_verdict();
  endtask : wait_irq
  task automatic t_reset();
    rd(STATE_OFS, 32'h0);
    rd(OPCODE_OFS, 32'h0);
    rd(IRQ_MSK_OFS, 32'h0);
    rd(STAT_OFS, 32'h0);
    rd(8'h40, 32'h0);
    chk(irq_o, 32'h0);
  endtask : t_reset
  task automatic t_disabled();
    pulse(4'hF);
    repeat (40) @(posedge clk_i);
    chk(cnt, 32'h0);
    chk(cs_n, 32'h1);
    wr(OPCODE_OFS, 32'hFB);
    wr(IRQ_MSK_OFS, 32'h3);
    rd(OPCODE_OFS, 32'hFB);
  endtask : t_disabled
  task automatic run_event(input int i);
    @(posedge clk_i);
    pwr <= 4'(i + 5);
    if (i < 4) ev <= 4'h8 >> i;
    else eject <= (i == 4);
    @(posedge clk_i);
    ev <= 4'h0;
    wait_irq();
    n = n + 8'h01;
    chk(tf[1], i < 4 ? 32'h80 >> i : 32'h02 >> (i - 4));
    chk(tf[2], 32'(i + 5));
    chk({tf[5], tf[4]}, exp_out);
    chk(tf[7], 32'hFB);
    chk(wseq, 32'h152F);
    chk(rseq, 32'h7FE5);
    exp_out = {8'hC0 + n, 8'hA0 + n};
    wr(IRQ_STS_OFS, 32'h1);
    rd(STATE_OFS, {exp_out, exp_out});
    chk(irq_o, 32'h0);
  endtask : run_event
  task automatic t_abort();
    int k;
    k = 0;
    wr(IRQ_MSK_OFS, 32'h1);
    pulse(4'h8);
    while ((rd_n !== 1'b0 || da !== TF_CMD) && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 500) chk(32'(k), 32'h0);
    if (k == 500) print_verdict();
    pulse(4'h8);
    repeat (20) @(posedge clk_i);
    rd(IRQ_STS_OFS, 32'h2);
    chk(irq_o, 32'h0);
    wait_irq();
    n = n + 8'h02;
    chk(tf[1], 32'h80);
    chk({tf[5], tf[4]}, exp_out);
    exp_out = {8'hC0 + n, 8'hA0 + n};
    rd(STATE_OFS, {exp_out, exp_out});
    rd(IRQ_STS_OFS, 32'h3);
  endtask : t_abort
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_disabled();
    for (int i = 0; i < 6; i++) run_event(i);
    t_abort();
    print_verdict();
  end
endmodule : tb_ata_event_notifier
